/* File: hdl/dcdcc_pkg.sv */
// Constants for the dc-dc converter digital control: register map, fields, reset values, timing.
// Assumes a 100 MHz system clock and byte-wide special-function-register access.
package dcdcc_pkg;

  // Register addresses on the special-function-register bus.
  localparam logic [7:0] DCDC_CONFIG_ADDR = 8'h96;
  localparam logic [7:0] DCDC_CONTROL_ADDR = 8'h97;

  // Reset values and writable-bit masks.
  localparam logic [7:0] DCDC_CONTROL_RESET = 8'h21;
  localparam logic [7:0] DCDC_CONFIG_RESET = 8'h00;
  localparam logic [7:0] DCDC_CONTROL_WMASK = 8'hef;
  localparam logic [7:0] DCDC_CONFIG_WMASK = 8'h7f;

  // Control register fields.
  localparam int CTL_MIN_PULSE_WIDTH_LSB = 6;
  localparam int CTL_SWSIZE_BIT = 5;
  localparam int CTL_RSVD_BIT = 4;
  localparam int CTL_SYNC_BIT = 3;
  localparam int CTL_OUTPUT_VOLTAGE_SELECT_LSB = 0;

  // Configuration register fields.
  localparam int CFG_RSVD_BIT = 7;
  localparam int CFG_DIV_LSB = 5;
  localparam int CFG_ADCINV_BIT = 4;
  localparam int CFG_CONV_CLOCK_INVERT_BIT = 3;
  localparam int CFG_ILIM_BIT = 2;
  localparam int CFG_FLOAT_BIT = 1;
  localparam int CFG_CONV_CLOCK_SOURCE_BIT = 0;

  // Clock source select encoding.
  localparam logic CLKSRC_LOCAL_OSC = 1'b0;
  localparam logic CLKSRC_SYSTEM = 1'b1;

  // Timing: the system clock period and the minimum pulse widths in ns.
  localparam int SYS_CLK_NS = 10;
  localparam int MIN_PULSE_WIDTH_01_NS = 20;
  localparam int MIN_PULSE_WIDTH_10_NS = 40;
  localparam int MIN_PULSE_WIDTH_11_NS = 80;
  localparam logic [3:0] MIN_PULSE_WIDTH_01_CYC = 4'((MIN_PULSE_WIDTH_01_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
  localparam logic [3:0] MIN_PULSE_WIDTH_10_CYC = 4'((MIN_PULSE_WIDTH_10_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
  localparam logic [3:0] MIN_PULSE_WIDTH_11_CYC = 4'((MIN_PULSE_WIDTH_11_NS + SYS_CLK_NS - 1) / SYS_CLK_NS);
  localparam logic [3:0] MIN_PULSE_WIDTH_NONE_CYC = 4'h0;

  // Target output voltages in millivolts, indexed by the voltage-select code.
  localparam logic [11:0] VOUT_MV_0 = 12'd1800;
  localparam logic [11:0] VOUT_MV_1 = 12'd1900;
  localparam logic [11:0] VOUT_MV_2 = 12'd2000;
  localparam logic [11:0] VOUT_MV_3 = 12'd2100;
  localparam logic [11:0] VOUT_MV_4 = 12'd2400;
  localparam logic [11:0] VOUT_MV_5 = 12'd2700;
  localparam logic [11:0] VOUT_MV_6 = 12'd3000;
  localparam logic [11:0] VOUT_MV_7 = 12'd3300;

endpackage

/* File: hdl/dcdcc_top.sv */
// Digital control of the step-up dc-dc converter: two byte registers and the control signals they steer.
// Assumes a synchronous special-function-register bus, and that the analog stage and local oscillator sit outside.
// Operation
// [RL1] Converter clock comes from the local oscillator or the system clock, chosen by one bit.
// [RL2] Divider lets system clocks above 1.6 MHz yield a 1.6 to 3.2 MHz clock.
// [RL3] Divider codes 00..11 divide by 1, 2, 4, 8; ignored with local oscillator.
// [RL4] Clock-invert bit set inverts the system clock entering the divider.
// [RL5] Source select 0 picks the local oscillator, 1 picks the system clock.
// [RL6] Sleep disables the converter; output node ties to battery by default.
// [RL7] Sleep-float bit set leaves the output node floating during sleep.
// [RL8] Minimum-pulse field in bits 7:6 gives none, 20, 40 or 80 ns.
// [RL9] Switch-size bit 5: 0 large switches, 1 small switches.
// [RL10] Sync bit 3 aligns ADC tracking and conversion clock to the switching cycle.
// [RL11] Software clears the ADC sample-clock divider while synchronisation is on.
// [RL12] Three-bit voltage code selects 1.8 to 3.3 V target output.
// [RL13] Control register resets to no minimum pulse, small switches, no sync, code 001.
// [RL14] Software should enable sync whenever the ADC runs with the converter.
// [RL15] Software only lowers the precision oscillator trim, never raises it.
// [RL16] Reserved control bit 4 reads 0 and ignores writes.
`timescale 1ns/1ns

module dcdcc_top #(
  parameter int ADDR_W = 8
) (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Register bus.
  input wire logic [ADDR_W-1:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  // Power mode.
  input wire logic sleep_mode,
  // Converter clock.
  output logic clock_from_system,
  output logic local_osc_enable,
  output logic conv_clk_tick,
  output logic conv_clk_phase,
  // Power stage.
  output logic conv_enable,
  output logic output_tied_to_battery,
  output logic output_floating,
  output logic [1:0] min_pulse_width,
  output logic [3:0] min_pulse_cycles,
  output logic switch_size_select,
  output logic peak_current_limit,
  output logic [2:0] output_voltage_select,
  output logic [11:0] target_output_mv,
  // ADC synchronisation.
  output logic adc_sync_enable,
  output logic adc_sar_clk_invert,
  output logic adc_sync_tick
);

  if (ADDR_W < 8)
  begin : g_addr_w_check
    $error("ADDR_W must be at least 8");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registers.

  logic [7:0] dcdc_control_q, dcdc_control_d;
  logic [7:0] dcdc_config_q, dcdc_config_d;
  logic [7:0] rdata_q, rdata_d;
  logic hit_control, hit_config;

  always_comb
  begin
    hit_control = (sfr_addr == ADDR_W'(dcdcc_pkg::DCDC_CONTROL_ADDR));
    hit_config = (sfr_addr == ADDR_W'(dcdcc_pkg::DCDC_CONFIG_ADDR));
    dcdc_control_d = dcdc_control_q;
    dcdc_config_d = dcdc_config_q;
    if (sfr_wr && hit_control)
    begin
      dcdc_control_d = sfr_wdata & dcdcc_pkg::DCDC_CONTROL_WMASK; // RL16
    end
    if (sfr_wr && hit_config)
    begin
      dcdc_config_d = sfr_wdata & dcdcc_pkg::DCDC_CONFIG_WMASK;
    end
    rdata_d = 8'h00;
    if (sfr_rd && hit_control)
    begin
      rdata_d = dcdc_control_q;
    end
    else if (sfr_rd && hit_config)
    begin
      rdata_d = dcdc_config_q;
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      dcdc_control_q <= dcdcc_pkg::DCDC_CONTROL_RESET; // RL13
      dcdc_config_q <= dcdcc_pkg::DCDC_CONFIG_RESET;
      rdata_q <= 8'h00;
    end
    else
    begin
      dcdc_control_q <= dcdc_control_d;
      dcdc_config_q <= dcdc_config_d;
      rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Converter clock divider.

  logic [1:0] div_code;
  logic [2:0] div_max, div_half;
  logic src_sys, clk_inv;
  logic [2:0] div_cnt_q, div_cnt_d;
  logic tick_q, tick_d;
  logic phase_q, phase_d;

  always_comb
  begin
    src_sys = (dcdc_config_q[dcdcc_pkg::CFG_CONV_CLOCK_SOURCE_BIT] == dcdcc_pkg::CLKSRC_SYSTEM); // RL5
    clk_inv = dcdc_config_q[dcdcc_pkg::CFG_CONV_CLOCK_INVERT_BIT];
    div_code = dcdc_config_q[dcdcc_pkg::CFG_DIV_LSB +: 2];
    div_max = 3'((4'h1 << div_code) - 4'h1); // RL3
    div_half = 3'((4'h1 << div_code) >> 1);
    div_cnt_d = 3'h0;
    tick_d = 1'b0;
    phase_d = 1'b0;
    if (src_sys) // RL1
    begin
      // The count runs down so that the tick marks the start of each converter period.
      if (div_cnt_q == 3'h0 || div_cnt_q > div_max)
      begin
        div_cnt_d = div_max; // RL2
      end
      else
      begin
        div_cnt_d = div_cnt_q - 3'h1;
      end
      tick_d = (div_cnt_d == div_max);
      // With divide by one no flop can follow the clock, so the phase only shows the inversion.
      phase_d = ((div_code != 2'b00) && (div_cnt_d >= div_half)) ^ clk_inv; // RL4
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      div_cnt_q <= 3'h0;
      tick_q <= 1'b0;
      phase_q <= 1'b0;
    end
    else
    begin
      div_cnt_q <= div_cnt_d;
      tick_q <= tick_d;
      phase_q <= phase_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Power stage and ADC controls.

  logic sel_sys_q, osc_en_q, en_q, tied_q, float_q, sw_q, ilim_q, sync_q, adcinv_q, synctick_q;
  logic sel_sys_d, osc_en_d, en_d, tied_d, float_d, sw_d, ilim_d, sync_d, adcinv_d, synctick_d;
  logic [1:0] mpw_q, mpw_d;
  logic [3:0] mpc_q, mpc_d;
  logic [2:0] output_voltage_select_q, output_voltage_select_d;
  logic [11:0] mv_q, mv_d;

  always_comb
  begin
    sel_sys_d = src_sys; // RL1
    osc_en_d = !src_sys && !sleep_mode;
    en_d = !sleep_mode; // RL6
    float_d = sleep_mode && dcdc_config_q[dcdcc_pkg::CFG_FLOAT_BIT]; // RL7
    tied_d = sleep_mode && !dcdc_config_q[dcdcc_pkg::CFG_FLOAT_BIT]; // RL6
    ilim_d = dcdc_config_q[dcdcc_pkg::CFG_ILIM_BIT];
    mpw_d = dcdc_control_q[dcdcc_pkg::CTL_MIN_PULSE_WIDTH_LSB +: 2];
    case (mpw_d) // RL8
      2'b00: mpc_d = dcdcc_pkg::MIN_PULSE_WIDTH_NONE_CYC;
      2'b01: mpc_d = dcdcc_pkg::MIN_PULSE_WIDTH_01_CYC;
      2'b10: mpc_d = dcdcc_pkg::MIN_PULSE_WIDTH_10_CYC;
      2'b11: mpc_d = dcdcc_pkg::MIN_PULSE_WIDTH_11_CYC;
      default: mpc_d = dcdcc_pkg::MIN_PULSE_WIDTH_NONE_CYC;
    endcase
    sw_d = dcdc_control_q[dcdcc_pkg::CTL_SWSIZE_BIT]; // RL9
    sync_d = dcdc_control_q[dcdcc_pkg::CTL_SYNC_BIT]; // RL10
    // The ADC clock inversion bit only counts while synchronised, and 0 means inverted.
    adcinv_d = sync_d && !dcdc_config_q[dcdcc_pkg::CFG_ADCINV_BIT];
    synctick_d = sync_d && tick_d; // RL10
    output_voltage_select_d = dcdc_control_q[dcdcc_pkg::CTL_OUTPUT_VOLTAGE_SELECT_LSB +: 3];
    case (output_voltage_select_d) // RL12
      3'h0: mv_d = dcdcc_pkg::VOUT_MV_0;
      3'h1: mv_d = dcdcc_pkg::VOUT_MV_1;
      3'h2: mv_d = dcdcc_pkg::VOUT_MV_2;
      3'h3: mv_d = dcdcc_pkg::VOUT_MV_3;
      3'h4: mv_d = dcdcc_pkg::VOUT_MV_4;
      3'h5: mv_d = dcdcc_pkg::VOUT_MV_5;
      3'h6: mv_d = dcdcc_pkg::VOUT_MV_6;
      3'h7: mv_d = dcdcc_pkg::VOUT_MV_7;
      default: mv_d = dcdcc_pkg::VOUT_MV_1;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sel_sys_q <= 1'b0;
      osc_en_q <= 1'b0;
      en_q <= 1'b0;
      tied_q <= 1'b0;
      float_q <= 1'b0;
      sw_q <= dcdcc_pkg::DCDC_CONTROL_RESET[dcdcc_pkg::CTL_SWSIZE_BIT];
      ilim_q <= 1'b0;
      sync_q <= 1'b0;
      adcinv_q <= 1'b0;
      synctick_q <= 1'b0;
      mpw_q <= 2'h0;
      mpc_q <= 4'h0;
      output_voltage_select_q <= dcdcc_pkg::DCDC_CONTROL_RESET[dcdcc_pkg::CTL_OUTPUT_VOLTAGE_SELECT_LSB +: 3];
      mv_q <= dcdcc_pkg::VOUT_MV_1;
    end
    else
    begin
      sel_sys_q <= sel_sys_d;
      osc_en_q <= osc_en_d;
      en_q <= en_d;
      tied_q <= tied_d;
      float_q <= float_d;
      sw_q <= sw_d;
      ilim_q <= ilim_d;
      sync_q <= sync_d;
      adcinv_q <= adcinv_d;
      synctick_q <= synctick_d;
      mpw_q <= mpw_d;
      mpc_q <= mpc_d;
      output_voltage_select_q <= output_voltage_select_d;
      mv_q <= mv_d;
    end
  end

  assign clock_from_system = sel_sys_q;
  assign local_osc_enable = osc_en_q;
  assign conv_clk_tick = tick_q;
  assign conv_clk_phase = phase_q;
  assign conv_enable = en_q;
  assign output_tied_to_battery = tied_q;
  assign output_floating = float_q;
  assign min_pulse_width = mpw_q;
  assign min_pulse_cycles = mpc_q;
  assign switch_size_select = sw_q;
  assign peak_current_limit = ilim_q;
  assign output_voltage_select = output_voltage_select_q;
  assign target_output_mv = mv_q;
  assign adc_sync_enable = sync_q;
  assign adc_sar_clk_invert = adcinv_q;
  assign adc_sync_tick = synctick_q;

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions.

  sequence s_div8_steady;
    src_sys && div_code == 2'b11 && !sfr_wr;
  endsequence

  sequence s_ctl_write_reserved;
    sfr_wr && hit_control && sfr_wdata[dcdcc_pkg::CTL_RSVD_BIT];
  endsequence

  property p_reserved_zero;
    @(posedge sys_clk) disable iff (rst)
      s_ctl_write_reserved |=> !dcdc_control_q[dcdcc_pkg::CTL_RSVD_BIT];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit stored"); // RL16
  // The tick must come from a count made under divide by 8, so the setting must stand a cycle earlier.
  property p_div8_period;
    @(posedge sys_clk) disable iff (rst)
      s_div8_steady ##1 (tick_q and s_div8_steady) ##1 s_div8_steady [*7] |=> tick_q;
  endproperty
  a_div8_period: assert property (p_div8_period) else $error("divide by 8 period wrong"); // RL3
  property p_div8_gap;
    @(posedge sys_clk) disable iff (rst)
      s_div8_steady ##1 (tick_q and s_div8_steady) |=> !tick_q [*6];
  endproperty
  a_div8_gap: assert property (p_div8_gap) else $error("divide by 8 tick too early"); // RL2
  property p_local_no_tick;
    @(posedge sys_clk) disable iff (rst)
      !src_sys [*2] |-> !tick_q && !clock_from_system;
  endproperty
  a_local_no_tick: assert property (p_local_no_tick) else $error("tick on local oscillator"); // RL1
  property p_div1_invert;
    @(posedge sys_clk) disable iff (rst)
      (src_sys && div_code == 2'b00 && !sfr_wr) [*2] |-> conv_clk_phase == clk_inv;
  endproperty
  a_div1_invert: assert property (p_div1_invert) else $error("inversion not shown"); // RL4
  property p_sleep_disable;
    @(posedge sys_clk) disable iff (rst)
      sleep_mode |=> !conv_enable && (output_floating != output_tied_to_battery);
  endproperty
  a_sleep_disable: assert property (p_sleep_disable) else $error("sleep output wrong"); // RL6
  property p_sleep_float;
    @(posedge sys_clk) disable iff (rst)
      sleep_mode && dcdc_config_q[dcdcc_pkg::CFG_FLOAT_BIT] |=> output_floating && !output_tied_to_battery;
  endproperty
  a_sleep_float: assert property (p_sleep_float) else $error("output not floating"); // RL7
  property p_min_pulse;
    @(posedge sys_clk) disable iff (rst)
      1'b1 |=> min_pulse_cycles == (min_pulse_width == 2'b00 ? 4'h0 : 4'h1 << min_pulse_width);
  endproperty
  a_min_pulse: assert property (p_min_pulse) else $error("minimum pulse count wrong"); // RL8
  property p_sync_tick;
    @(posedge sys_clk) disable iff (rst)
      adc_sync_tick |-> conv_clk_tick && adc_sync_enable;
  endproperty
  a_sync_tick: assert property (p_sync_tick) else $error("sync tick without cycle"); // RL10
  property p_reset_value;
    @(posedge sys_clk)
      rst |=> dcdc_control_q == 8'h21 && output_voltage_select == 3'h1 && switch_size_select;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("control reset value wrong"); // RL13
  property p_output_voltage_select_mv;
    @(posedge sys_clk) disable iff (rst)
      output_voltage_select == 3'h7 |-> target_output_mv == 12'd3300;
  endproperty
  a_output_voltage_select_mv: assert property (p_output_voltage_select_mv) else $error("voltage table wrong"); // RL12

endmodule

/* File: dv/dcdcc_stage_model.sv */
// Behavioural stand-in for the analog switching stage and the ADC sampler.
// Assumes one-cycle converter and sync ticks on sys_clk from the control block.
`timescale 1ns/1ns

module dcdcc_stage_model (
  // Clock and reset.
  input wire logic sys_clk,
  input wire logic rst,
  // Converter side.
  input wire logic conv_enable,
  input wire logic conv_clk_tick,
  // ADC side.
  input wire logic adc_sync_enable,
  input wire logic adc_sync_tick,
  // Observation.
  output logic adc_active,
  output logic [4:0] adc_sample_clock_div,
  output logic [15:0] tick_cnt,
  output logic [15:0] sync_cnt
);
  logic [4:0] div_d;
  logic [15:0] tick_d;
  logic [15:0] sync_d;

  // The sampler only runs beside a running converter while synchronised.
  assign adc_active = conv_enable && adc_sync_enable;

  always_comb
  begin
    div_d = adc_sync_enable ? 5'h00 : 5'h04;
    tick_d = tick_cnt + 16'(conv_clk_tick);
    sync_d = sync_cnt + 16'(adc_sync_tick);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      adc_sample_clock_div <= 5'h04;
      tick_cnt <= 16'h0000;
      sync_cnt <= 16'h0000;
    end
    else
    begin
      adc_sample_clock_div <= div_d;
      tick_cnt <= tick_d;
      sync_cnt <= sync_d;
    end
  end
endmodule

/* File: dv/dcdcc_tb_top.sv */
// Self-checking bench for the dc-dc converter control block.
// Assumes the stage model beside it and a 100 MHz clock made here.
`timescale 1ns/1ns

module dcdcc_tb_top;
  localparam logic [7:0] CTRL = dcdcc_pkg::DCDC_CONTROL_ADDR;
  localparam logic [7:0] CFG = dcdcc_pkg::DCDC_CONFIG_ADDR;
  logic sys_clk, rst, sfr_wr, sfr_rd, sleep_mode;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, ctl, cfg, lf;
  logic clock_from_system, local_osc_enable, conv_clk_tick, conv_clk_phase, conv_enable;
  logic output_tied_to_battery, output_floating, switch_size_select, peak_current_limit;
  logic adc_sync_enable, adc_sar_clk_invert, adc_sync_tick;
  logic [1:0] min_pulse_width;
  logic [3:0] min_pulse_cycles;
  logic [2:0] output_voltage_select;
  logic [11:0] target_output_mv;
  logic [15:0] tick_cnt, sync_cnt, t0, s0;
  logic adc_active;
  logic [4:0] adc_sample_clock_div;
  logic [7:0] exp_q[$];
  logic [11:0] mv_tab [8] = '{12'h708, 12'h76c, 12'h7d0, 12'h834, 12'h960, 12'ha8c, 12'hbb8, 12'hce4};
  logic [3:0] cyc_tab [4] = '{4'h0, 4'h2, 4'h4, 4'h8};
  int error_cnt = 0;
  int cmp_count = 0;

  dcdcc_top dcdcc_top_inst (.sys_clk(sys_clk), .rst(rst), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
    .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata), .sleep_mode(sleep_mode),
    .clock_from_system(clock_from_system), .local_osc_enable(local_osc_enable),
    .conv_clk_tick(conv_clk_tick), .conv_clk_phase(conv_clk_phase), .conv_enable(conv_enable),
    .output_tied_to_battery(output_tied_to_battery), .output_floating(output_floating),
    .min_pulse_width(min_pulse_width), .min_pulse_cycles(min_pulse_cycles),
    .switch_size_select(switch_size_select), .peak_current_limit(peak_current_limit),
    .output_voltage_select(output_voltage_select), .target_output_mv(target_output_mv),
    .adc_sync_enable(adc_sync_enable), .adc_sar_clk_invert(adc_sar_clk_invert),
    .adc_sync_tick(adc_sync_tick));

  dcdcc_stage_model dcdcc_stage_model_inst (.sys_clk(sys_clk), .rst(rst), .conv_enable(conv_enable),
    .conv_clk_tick(conv_clk_tick), .adc_sync_enable(adc_sync_enable), .adc_sync_tick(adc_sync_tick),
    .adc_active(adc_active), .adc_sample_clock_div(adc_sample_clock_div), .tick_cnt(tick_cnt),
    .sync_cnt(sync_cnt));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction

  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    cmp_count++;
    if (g !== e)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic end_of_test();
    $display("Comparisons %0d, mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= 1'b1;
    @(posedge sys_clk);
    sfr_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    sfr_addr <= a;
    sfr_rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge sys_clk);
    sfr_rd <= 1'b0;
  endtask

  task automatic settle();
    repeat (3) @(posedge sys_clk);
    #1;
  endtask

  task automatic wait_tick();
    for (int k = 0; k < 20; k++)
    begin
      if (conv_clk_tick === 1'b1)
        return;
      @(posedge sys_clk);
      #1;
    end
    chk("tick_seen", 16'h0001, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // Read data stands for one cycle after the taking edge.
  always @(posedge sys_clk)
  begin
    if (sfr_rd === 1'b1 && rst === 1'b0)
    begin
      #1;
      chk("sfr_rdata", {8'h00, exp_q.pop_front()}, {8'h00, sfr_rdata});
    end
  end

  initial
  begin
    repeat (20000) @(posedge sys_clk);
    error_cnt++;
    end_of_test();
  end

  initial
  begin
    rst = 1'b1;
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
    sleep_mode = 1'b0;
    lf = 8'h20;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    rd(CTRL, 8'h21);
    rd(CFG, 8'h00);
    settle();
    chk("switch_size_select", 16'h0001, 16'(switch_size_select));
    chk("target_output_mv", 16'(mv_tab[1]), 16'(target_output_mv));
    chk("min_pulse_cycles", 16'h0000, 16'(min_pulse_cycles));
    $display("test reset values done");
    for (int v = 0; v < 8; v++)
    begin
      lf = lfsr(lf);
      ctl = {2'(v), lf[5:3], 3'(v)};
      wr(CTRL, ctl);
      rd(CTRL, ctl & 8'hef);
      settle();
      chk("target_output_mv", 16'(mv_tab[v]), 16'(target_output_mv));
      chk("output_voltage_select", 16'(v), 16'(output_voltage_select));
      chk("min_pulse_width", 16'(ctl[7:6]), 16'(min_pulse_width));
      chk("min_pulse_cycles", 16'(cyc_tab[ctl[7:6]]), 16'(min_pulse_cycles));
      chk("switch_size_select", 16'(ctl[5]), 16'(switch_size_select));
      chk("adc_sync_enable", 16'(ctl[3]), 16'(adc_sync_enable));
      chk("adc_sar_clk_invert", 16'(ctl[3]), 16'(adc_sar_clk_invert));
    end
    $display("test control fields done");
    wr(CTRL, 8'h28);
    for (int d = 0; d < 4; d++)
    begin
      for (int i = 0; i < 2; i++)
      begin
        lf = lfsr(lf);
        cfg = {1'b0, 2'(d), lf[0], 1'(i), lf[1], 1'b0, 1'b1};
        wr(CFG, cfg);
        rd(CFG, cfg);
        settle();
        t0 = tick_cnt;
        s0 = sync_cnt;
        repeat (32) @(posedge sys_clk);
        #1;
        chk("tick_count", 16'h0020 >> d, tick_cnt - t0);
        chk("sync_count", 16'h0020 >> d, sync_cnt - s0);
        chk("adc_sar_clk_invert", 16'(!cfg[4]), 16'(adc_sar_clk_invert));
        chk("peak_current_limit", 16'(cfg[2]), 16'(peak_current_limit));
        chk("clock_from_system", 16'h0001, 16'(clock_from_system));
        chk("adc_sample_clock_div", 16'h0000, 16'(adc_sample_clock_div));
        chk("adc_active", 16'h0001, 16'(adc_active));
        wait_tick();
        chk("conv_clk_phase", 16'(cfg[3] ^ (d != 0)), 16'(conv_clk_phase));
      end
    end
    wr(CFG, 8'h60);
    settle();
    t0 = tick_cnt;
    repeat (32) @(posedge sys_clk);
    #1;
    chk("tick_count", 16'h0000, tick_cnt - t0);
    chk("clock_from_system", 16'h0000, 16'(clock_from_system));
    chk("local_osc_enable", 16'h0001, 16'(local_osc_enable));
    $display("test converter clock done");
    for (int f = 0; f < 2; f++)
    begin
      wr(CFG, {6'h00, 1'(f), 1'b0});
      @(posedge sys_clk);
      sleep_mode <= 1'b1;
      settle();
      chk("conv_enable", 16'h0000, 16'(conv_enable));
      chk("output_tied_to_battery", 16'(f == 0), 16'(output_tied_to_battery));
      chk("output_floating", 16'(f), 16'(output_floating));
      chk("local_osc_enable", 16'h0000, 16'(local_osc_enable));
      @(posedge sys_clk);
      sleep_mode <= 1'b0;
      settle();
      chk("conv_enable", 16'h0001, 16'(conv_enable));
      chk("output_floating", 16'h0000, 16'(output_floating));
    end
    $display("test sleep done");
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    rd(CTRL, 8'h28);
    wr(CFG, 8'hff);
    rd(CFG, 8'h7f);
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    rd(CTRL, 8'h21);
    settle();
    $display("test unmapped and reset done");
    end_of_test();
  end
endmodule
